// >>> rx_status_consts.vh
`ifndef RX_STATUS_CONSTS_VH
`define RX_STATUS_CONSTS_VH

// register addresses
`define ADDR_COMPRESSED_STREAM_DETECT 8'h12
`define ADDR_RECEIVER_CLOCK_RATE_STATUS 8'h13
`define ADDR_RECEIVER_ERROR_EVENT_STATUS 8'h14
`define ADDR_STATUS2_MASK 8'h16
`define ADDR_PREAMBLE_FIRST 8'h29
`define ADDR_PREAMBLE_LAST 8'h2C

// non-pcm detection fields
`define BIT_BURST_FORMAT 0
`define BIT_DISC_SURROUND 1

// status 2 fields
`define BIT_CHANSTAT_CRC 7
`define BIT_PARITY 6
`define BIT_VALIDITY 5
`define BIT_BIPHASE 4
`define BIT_SUBCODE_CHG 3
`define BIT_UNLOCK 2
`define BIT_SUBCODE_CRC 1
`define BIT_BUFFER_DONE 0

// rate field codes
`define RATE_UNKNOWN 2'h0
`define RATE_128FS 2'h1
`define RATE_256FS 2'h2
`define RATE_512FS 2'h3

// reset values
`define RESET_STATUS 8'h00
`define RESET_MASK 8'h00
`define RESET_UNLOCK 8'h04

// frame period thresholds in clock cycles between frame starts
`define FRAME_FAST_MAX 16'h0100
`define FRAME_MID_MAX 16'h0200
`define FRAME_SLOW_MAX 16'h0800

`endif

// >>> rate_estimator.v
`timescale 1ns/1ps
`include "rx_status_consts.vh"
// measures cycles between frame starts and maps them onto a rate code
module rate_estimator #(
   parameter CW = 16
) (
   input wire clk_i,
   input wire rst_i,
   input wire locked_i,
   input wire frame_start_i,
   output reg [1:0] rate_o
);
   reg [CW-1:0] count_q;
   reg [CW-1:0] count_d;
   reg [1:0] rate_d;

   always @* begin
      count_d = count_q;
      rate_d = rate_o;
      if (!locked_i) begin
         count_d = {CW{1'b0}};
         rate_d = `RATE_UNKNOWN;
      end else if (frame_start_i) begin
         count_d = {CW{1'b0}};
         // faster frames leave less headroom for oversampling
         if (count_q == {CW{1'b0}})
            rate_d = rate_o;
         else if (count_q <= `FRAME_FAST_MAX)
            rate_d = `RATE_128FS;
         else if (count_q <= `FRAME_MID_MAX)
            rate_d = `RATE_256FS;
         else if (count_q <= `FRAME_SLOW_MAX)
            rate_d = `RATE_512FS;
         else
            rate_d = `RATE_UNKNOWN;
      end else if (count_q != {CW{1'b1}}) begin
         count_d = count_q + {{(CW-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_q <= {CW{1'b0}};
         rate_o <= `RATE_UNKNOWN;
      end else begin
         count_q <= count_d;
         rate_o <= rate_d;
      end
   end
endmodule

// >>> receiver_status_reporting.v
// Behaviour
// - bit 0 of detection register shows compressed burst format.
// - with burst flag set, burst type and length readable at 0x29-0x2C.
// - bit 1 of detection register shows disc surround playback.
// - detection register at 0x12 is read-only; bits 7:2 read zero.
// - two-bit read-only field gives highest recovered clock rate.
// - estimate frame rate, derive max rate, drive recovered clock, load field.
// - rate codes: 00 unknown, 01 128fs, 10 256fs, 11 512fs.
// - status register 1 at 0x13 read-only; rate in bits 1:0.
// - status register 2 at 0x14 read-only with eight error and event flags.
// - status 2 flag interrupts only when unmasked in register 0x16.
// - unlock flag is 1 unless decoder and recovery pll both locked.
// - subcode change flag set when subcode data changes.
// - biphase, parity and channel status crc flags follow detected errors.
`timescale 1ns/1ps
`include "rx_status_consts.vh"
module receiver_status_reporting #(
   parameter CW = 16
) (
   // clock and reset
   input wire CLK_I,
   input wire RST_I,
   // register access from the serial control port
   input wire [7:0] ADDR_I,
   input wire WR_I,
   input wire [7:0] WDATA_I,
   output reg [7:0] RDATA_O,
   // decoder events and levels
   input wire BURST_FORMAT_I,
   input wire DISC_SURROUND_DETECT_I,
   input wire [7:0] PREAMBLE_BYTE_I,
   input wire FRAME_START_I,
   input wire DECODER_LOCKED_I,
   input wire RECOVERY_PLL_LOCKED_I,
   input wire CHANSTAT_CRC_ERROR_I,
   input wire PARITY_ERROR_I,
   input wire VALIDITY_FLAG_I,
   input wire BIPHASE_ERROR_I,
   input wire SUBCODE_CHANGED_I,
   input wire SUBCODE_CRC_ERROR_I,
   input wire BUFFER_TRANSFER_DONE_I,
   // recovery pll rate request and interrupt
   output wire [1:0] MAX_RECOVERED_RATE_O,
   output wire INT_O
);
   reg [1:0] detect_q;
   reg [1:0] detect_d;
   reg [7:0] status2_q;
   reg [7:0] status2_d;
   reg [7:0] mask_q;
   reg [7:0] mask_d;
   reg [7:0] preamble_q [0:3];
   reg [7:0] rdata_d;
   reg [1:0] pre_idx;
   wire [1:0] rate;
   wire locked;
   integer i;

   assign locked = DECODER_LOCKED_I & RECOVERY_PLL_LOCKED_I;

   rate_estimator #(
      .CW(CW)
   ) u_rate (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .locked_i(locked),
      .frame_start_i(FRAME_START_I),
      .rate_o(rate)
   );

   assign MAX_RECOVERED_RATE_O = rate;

   always @* begin
      detect_d[`BIT_BURST_FORMAT] = BURST_FORMAT_I;
      detect_d[`BIT_DISC_SURROUND] = DISC_SURROUND_DETECT_I;
      status2_d[`BIT_CHANSTAT_CRC] = CHANSTAT_CRC_ERROR_I;
      status2_d[`BIT_PARITY] = PARITY_ERROR_I;
      status2_d[`BIT_VALIDITY] = VALIDITY_FLAG_I;
      status2_d[`BIT_BIPHASE] = BIPHASE_ERROR_I;
      status2_d[`BIT_SUBCODE_CHG] = SUBCODE_CHANGED_I;
      status2_d[`BIT_UNLOCK] = ~locked;
      status2_d[`BIT_SUBCODE_CRC] = SUBCODE_CRC_ERROR_I;
      status2_d[`BIT_BUFFER_DONE] = BUFFER_TRANSFER_DONE_I;
      mask_d = mask_q;
      if (WR_I && ADDR_I == `ADDR_STATUS2_MASK)
         mask_d = WDATA_I;
   end

   always @* begin
      pre_idx = ADDR_I[1:0] - 2'h1;
      case (ADDR_I)
         `ADDR_COMPRESSED_STREAM_DETECT: rdata_d = {6'h00, detect_q};
         `ADDR_RECEIVER_CLOCK_RATE_STATUS: rdata_d = {6'h00, rate};
         `ADDR_RECEIVER_ERROR_EVENT_STATUS: rdata_d = status2_q;
         `ADDR_STATUS2_MASK: rdata_d = mask_q;
         default: begin
            rdata_d = 8'h00;
            if (ADDR_I >= `ADDR_PREAMBLE_FIRST && ADDR_I <= `ADDR_PREAMBLE_LAST)
               rdata_d = preamble_q[pre_idx];
         end
      endcase
   end

   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         detect_q <= 2'h0;
         status2_q <= `RESET_UNLOCK;
         mask_q <= `RESET_MASK;
         RDATA_O <= 8'h00;
         for (i = 0; i < 4; i = i + 1)
            preamble_q[i] <= 8'h00;
      end else begin
         // status registers ignore writes
         detect_q <= detect_d;
         status2_q <= status2_d;
         mask_q <= mask_d;
         RDATA_O <= rdata_d;
         // preamble bytes shift in on each frame start while a burst stream is seen
         if (BURST_FORMAT_I && FRAME_START_I) begin
            preamble_q[0] <= preamble_q[1];
            preamble_q[1] <= preamble_q[2];
            preamble_q[2] <= preamble_q[3];
            preamble_q[3] <= PREAMBLE_BYTE_I;
         end
      end
   end

   assign INT_O = |(status2_q & mask_q);
endmodule

// >>> rsr_properties.sv
`timescale 1ns/1ps
module rsr_checker (
   input wire CLK_I,
   input wire RST_I,
   input wire [7:0] ADDR_I,
   input wire WR_I,
   input wire [7:0] WDATA_I,
   input wire [7:0] RDATA_O,
   input wire DECODER_LOCKED_I,
   input wire RECOVERY_PLL_LOCKED_I,
   input wire PARITY_ERROR_I,
   input wire [1:0] MAX_RECOVERED_RATE_O,
   input wire INT_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   a_rate_nolock: assert property (!(DECODER_LOCKED_I && RECOVERY_PLL_LOCKED_I) |=>
      MAX_RECOVERED_RATE_O == 2'h0) else $error("rate without lock");
   a_detect_zero: assert property (ADDR_I == 8'h12 |=> RDATA_O[7:2] == 6'h00)
      else $error("detect high bits");
   a_rate_read: assert property (ADDR_I == 8'h13 |=>
      RDATA_O == {6'h00, $past(MAX_RECOVERED_RATE_O)}) else $error("rate read");
   a_unlock_read: assert property (ADDR_I == 8'h14 && !$past(DECODER_LOCKED_I) |=>
      RDATA_O[2]) else $error("unlock read");
   a_parity_read: assert property (ADDR_I == 8'h14 |=>
      RDATA_O[6] == $past(PARITY_ERROR_I, 2)) else $error("parity read");
   a_mask_back: assert property (WR_I && ADDR_I == 8'h16 ##1 ADDR_I == 8'h16 |=>
      RDATA_O == $past(WDATA_I, 2)) else $error("mask read");
   a_int_masked: assert property (ADDR_I == 8'h16 && !WR_I ##1 RDATA_O == 8'h00 |->
      !INT_O) else $error("masked irq");
   a_int_merge: assert property (ADDR_I == 8'h16 && !WR_I ##1
      RDATA_O[6] && $past(PARITY_ERROR_I) |-> INT_O) else $error("missing irq");
endmodule

// >>> host_port_model.sv
`timescale 1ns/1ps
module host_port_model (
   input wire clk_i,
   input wire [7:0] rdata_i,
   output reg [7:0] addr_o = 8'h00,
   output reg wr_o = 1'b0,
   output reg [7:0] wdata_o = 8'h00
);
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk_i) #1;
      addr_o = a;
      wr_o = 1'b1;
      wdata_o = d;
      @(posedge clk_i) #1;
      wr_o = 1'b0;
      wdata_o = ~d;
   endtask
   task rd(input [7:0] a, output [7:0] d);
      @(posedge clk_i) #1;
      addr_o = a;
      @(posedge clk_i) #1;
      d = rdata_i;
   endtask
endmodule

// >>> tb_receiver_status_reporting.sv
`timescale 1ns/1ps
module tb_receiver_status_reporting;
   reg clk = 1'b0, rst = 1'b1, burst = 1'b0, disc = 1'b0, frame = 1'b0, lk = 1'b0;
   reg [7:0] fl = 8'h00, pre = 8'h00, d;
   wire [7:0] addr, wdata, rdata;
   wire wr, irq;
   wire [1:0] rate;
   integer err_total = 0, n_tests = 0, i;
   always #20 clk = ~clk;
   host_port_model host_port_model_inst (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
      .wr_o(wr), .wdata_o(wdata));
   receiver_status_reporting receiver_status_reporting_inst (.CLK_I(clk), .RST_I(rst),
      .ADDR_I(addr), .WR_I(wr), .WDATA_I(wdata), .RDATA_O(rdata), .BURST_FORMAT_I(burst),
      .DISC_SURROUND_DETECT_I(disc), .PREAMBLE_BYTE_I(pre), .FRAME_START_I(frame),
      .DECODER_LOCKED_I(lk), .RECOVERY_PLL_LOCKED_I(lk), .CHANSTAT_CRC_ERROR_I(fl[7]),
      .PARITY_ERROR_I(fl[6]), .VALIDITY_FLAG_I(fl[5]), .BIPHASE_ERROR_I(fl[4]),
      .SUBCODE_CHANGED_I(fl[3]), .SUBCODE_CRC_ERROR_I(fl[1]),
      .BUFFER_TRANSFER_DONE_I(fl[0]), .MAX_RECOVERED_RATE_O(rate), .INT_O(irq));
   task final_report;
      if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input [7:0] a, input [7:0] e, input [7:0] g);
      n_tests = n_tests + 1;
      if (g !== e) begin
         $display("unexpected reg_%h exp %h got %h", a, e, g);
         err_total = err_total + 1;
      end
   endtask
   task rdc(input [7:0] a, input [7:0] e);
      host_port_model_inst.rd(a, d);
      chk(a, e, d);
   endtask
   task fr(input [15:0] p);
      @(posedge clk) #1;
      frame = 1'b1;
      pre = pre + 8'h01;
      @(posedge clk) #1;
      frame = 1'b0;
      repeat (p - 16'h0002) @(posedge clk);
   endtask
   task ratechk(input [15:0] p, input [7:0] e);
      repeat (3) fr(p);
      rdc(8'h13, e);
      chk(8'hF1, e, {6'h00, rate});
   endtask
   initial begin
      #2000000;
      err_total = err_total + 1;
      final_report;
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      rdc(8'h14, 8'h04);
      rdc(8'h13, 8'h00);
      rdc(8'h30, 8'h00);
      host_port_model_inst.wr(8'h0F, 8'h12);
      host_port_model_inst.wr(8'h10, 8'h00);
      host_port_model_inst.wr(8'h11, 8'h00);
      rdc(8'h0F, 8'h00);
      burst = 1'b1;
      disc = 1'b1;
      lk = 1'b1;
      rdc(8'h12, 8'h03);
      host_port_model_inst.wr(8'h12, 8'hFF);
      rdc(8'h12, 8'h03);
      ratechk(16'h0080, 8'h01);
      ratechk(16'h0180, 8'h02);
      ratechk(16'h0400, 8'h03);
      host_port_model_inst.wr(8'h0E, {6'h00, rate});
      rdc(8'h0E, 8'h00);
      ratechk(16'h0900, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         rdc(8'h29 + i[7:0], 8'h09 + i[7:0]);
      end
      ratechk(16'h0101, 8'h01);
      ratechk(16'h0102, 8'h02);
      ratechk(16'h0801, 8'h03);
      for (i = 0; i < 8; i = i + 1) begin
         fl = 8'h01 << i;
         lk = (i != 2);
         rdc(8'h14, 8'h01 << i);
      end
      lk = 1'b1;
      fl = 8'h40;
      rdc(8'h16, 8'h00);
      chk(8'hF0, 8'h00, {7'h00, irq});
      host_port_model_inst.wr(8'h16, 8'h40);
      chk(8'hF0, 8'h01, {7'h00, irq});
      host_port_model_inst.wr(8'h16, 8'hBF);
      chk(8'hF0, 8'h00, {7'h00, irq});
      host_port_model_inst.wr(8'h14, 8'h00);
      rdc(8'h14, 8'h40);
      final_report;
   end
endmodule
bind receiver_status_reporting rsr_checker rsr_checker_inst (.CLK_I(CLK_I), .RST_I(RST_I),
   .ADDR_I(ADDR_I), .WR_I(WR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
   .DECODER_LOCKED_I(DECODER_LOCKED_I), .RECOVERY_PLL_LOCKED_I(RECOVERY_PLL_LOCKED_I),
   .PARITY_ERROR_I(PARITY_ERROR_I), .MAX_RECOVERED_RATE_O(MAX_RECOVERED_RATE_O),
   .INT_O(INT_O));
